// ---- src/ptm_timer.sv ----
// three-channel 8-bit programmable down-counter timer
//
// Chosen here: the register addresses and strobed register access.
`default_nettype none
module ptm_timer
    import ptm_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic low_speed_source_clock_i,
    input wire logic high_speed_source_clock_i,
    input wire logic filter_ref_clock_i,
    input wire logic event_input_pin_i,
    input wire ptm_pkg::ptm_bus_t bus_i,
    output logic [7:0] rdata_o,
    output logic [2:0] timer_pulse_output_o,
    output logic [1:0] compare_match_o,
    output logic irq_o
);
    import ptm_pkg::*;

    // ----------------------------------------
    // synchronisers and edge detection
    // ----------------------------------------
    logic [3:0] sync1_reg;
    logic [3:0] sync2_reg;
    logic [3:0] sync3_reg;
    logic slow_rise;
    logic fast_rise;
    logic ref_fall;
    logic pin_lvl;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync1_reg <= 4'h0;
            sync2_reg <= 4'h0;
            sync3_reg <= 4'h0;
        end else begin
            sync1_reg <= {event_input_pin_i, filter_ref_clock_i,
                          high_speed_source_clock_i,
                          low_speed_source_clock_i};
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    // fast source is sampled, so it must stay well below clk_i / 2
    assign slow_rise = sync2_reg[0] & ~sync3_reg[0];
    assign fast_rise = sync2_reg[1] & ~sync3_reg[1];
    assign ref_fall = ~sync2_reg[2] & sync3_reg[2];
    assign pin_lvl = sync2_reg[3];

    // ----------------------------------------
    // control registers
    // ----------------------------------------
    logic [3:0] mode_reg;
    logic [2:0] cksel_reg;
    logic [2:0] run_reg;
    logic [1:0] ps_reg [NUM_TMR];
    logic [1:0] pwm_reg;
    logic [7:0] rld_reg [NUM_TMR];
    logic [7:0] cmp_reg [2];
    logic [2:0] umsk_reg;
    logic [1:0] cmsk_reg;
    logic [2:0] rst_strobe;
    logic wr_ctl;

    assign wr_ctl = bus_i.wr;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_reg <= 4'h0;
            cksel_reg <= 3'h0;
            pwm_reg <= 2'h0;
            umsk_reg <= 3'h0;
            cmsk_reg <= 2'h0;
        end else if (wr_ctl) begin
            unique case (bus_i.addr)
                ADR_MODE: mode_reg <= bus_i.wdata[3:0];
                ADR_CKSEL: cksel_reg <= bus_i.wdata[2:0];
                ADR_PWM: pwm_reg <= bus_i.wdata[1:0];
                ADR_UMSK: umsk_reg <= bus_i.wdata[2:0];
                ADR_CMSK: cmsk_reg <= bus_i.wdata[1:0];
                default: ;
            endcase
        end
    end

    // ----------------------------------------
    // per-timer prescaler, counter, output
    // ----------------------------------------
    logic [7:0] cnt_reg [NUM_TMR];
    logic [2:0] uf;
    logic [1:0] cm;
    logic [2:0] tick;
    logic [2:0] pulse_reg;
    logic [1:0] cm_reg;
    logic cascade;
    logic ev_tick;

    assign cascade = mode_reg[MODE_CASCADE];

    // ----------------------------------------
    // event input: polarity and noise filter
    // ----------------------------------------
    logic ev_lvl_reg;
    logic [1:0] flt_cnt_reg;
    logic ev_prev_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ev_lvl_reg <= 1'b0;
            flt_cnt_reg <= 2'h0;
        end else if (!mode_reg[MODE_FILTER]) begin
            ev_lvl_reg <= pin_lvl;
            flt_cnt_reg <= 2'h0;
        end else if (pin_lvl == ev_lvl_reg) begin
            flt_cnt_reg <= 2'h0; // glitch shorter than window rejected
        end else if (ref_fall) begin
            if (flt_cnt_reg == 2'(FILTER_EDGES - 1)) begin
                ev_lvl_reg <= pin_lvl;
                flt_cnt_reg <= 2'h0;
            end else begin
                flt_cnt_reg <= flt_cnt_reg + 2'h1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ev_prev_reg <= 1'b0;
        end else begin
            ev_prev_reg <= ev_lvl_reg;
        end
    end

    assign ev_tick = mode_reg[MODE_POL] ? (ev_lvl_reg & ~ev_prev_reg)
                                        : (~ev_lvl_reg & ev_prev_reg);

    genvar g;
    generate
        for (g = 0; g < NUM_TMR; g++) begin : g_tmr
            logic [7:0] pre_reg;
            logic src;
            logic pre_out;
            logic running;
            logic [7:0] next;

            assign src = cksel_reg[g] ? fast_rise : slow_rise;
            always_comb begin
                unique case (ps_reg[g])
                    PS_DIV1: pre_out = src;
                    PS_DIV4: pre_out = src & (pre_reg[1:0] == 2'h3);
                    PS_DIV32: pre_out = src & (pre_reg[4:0] == 5'h1F);
                    PS_DIV256: pre_out = src & (pre_reg == 8'hFF);
                endcase
            end

            // timer 1 follows timer 0 run bit in cascade
            assign running = (g == 1 && cascade) ? run_reg[0] : run_reg[g];

            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    pre_reg <= 8'h00;
                end else if (running && src) begin
                    pre_reg <= pre_reg + 8'h01;
                end
            end

            if (g == 0) begin : g_t0
                assign tick[g] = mode_reg[MODE_EVENT] ? (running & ev_tick)
                                                      : (running & pre_out);
            end else if (g == 1) begin : g_t1
                assign tick[g] = cascade ? uf[0] : (running & pre_out);
            end else begin : g_t2
                assign tick[g] = running & pre_out;
            end

            assign uf[g] = tick[g] & (cnt_reg[g] == 8'h00);
            assign next = uf[g] ? rld_reg[g] : cnt_reg[g] - 8'h01;

            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    cnt_reg[g] <= RST_BYTE;
                end else if (rst_strobe[g]) begin
                    cnt_reg[g] <= rld_reg[g];
                end else if (tick[g]) begin
                    cnt_reg[g] <= next;
                end
            end

            if (g < 2) begin : g_pwm
                logic pwm_on;
                assign pwm_on = pwm_reg[g];
                // match only on the decrement into the compare value
                assign cm[g] = pwm_on & tick[g] & ~uf[g] &
                               (next == cmp_reg[g]);
                always_ff @(posedge clk_i) begin
                    if (rst_i) begin
                        pulse_reg[g] <= 1'b0;
                    end else if (pwm_on) begin
                        if (uf[g]) begin
                            pulse_reg[g] <= 1'b1;
                        end else if (cm[g]) begin
                            pulse_reg[g] <= 1'b0;
                        end
                    end else if (uf[g]) begin
                        pulse_reg[g] <= ~pulse_reg[g];
                    end
                end
            end else begin : g_div
                always_ff @(posedge clk_i) begin
                    if (rst_i) begin
                        pulse_reg[g] <= 1'b0;
                    end else if (uf[g]) begin
                        pulse_reg[g] <= ~pulse_reg[g];
                    end
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // per-timer control registers
    // ----------------------------------------
    generate
        for (g = 0; g < NUM_TMR; g++) begin : g_ctl
            logic hit;
            assign hit = wr_ctl && (bus_i.addr == ADR_CTL0 + 5'(g));
            assign rst_strobe[g] = hit & bus_i.wdata[CTL_RST];
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    run_reg[g] <= 1'b0;
                    ps_reg[g] <= PS_DIV1;
                    rld_reg[g] <= RST_BYTE;
                end else begin
                    if (hit) begin
                        run_reg[g] <= bus_i.wdata[CTL_RUN];
                        ps_reg[g] <= bus_i.wdata[CTL_PS_LO +: 2];
                    end
                    if (wr_ctl && bus_i.addr == ADR_RLD0 + 5'(g)) begin
                        rld_reg[g] <= bus_i.wdata;
                    end
                end
            end
        end
        for (g = 0; g < 2; g++) begin : g_cmp
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    cmp_reg[g] <= RST_BYTE;
                end else if (wr_ctl && bus_i.addr == ADR_CMP0 + 5'(g)) begin
                    cmp_reg[g] <= bus_i.wdata;
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // interrupt flags
    // ----------------------------------------
    logic [2:0] uflg_reg;
    logic [1:0] cflg_reg;
    logic [2:0] uset;
    logic [1:0] cset;

    assign uset = {uf[2], uf[1], uf[0] & ~cascade};
    assign cset = cascade ? {cm[1] | cm[0], 1'b0} : cm;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            uflg_reg <= 3'h0;
            cflg_reg <= 2'h0;
        end else begin
            // set wins over a same-cycle clear
            uflg_reg <= (uflg_reg & ~((wr_ctl && bus_i.addr == ADR_UFLG)
                         ? bus_i.wdata[2:0] : 3'h0)) | uset;
            cflg_reg <= (cflg_reg & ~((wr_ctl && bus_i.addr == ADR_CFLG)
                         ? bus_i.wdata[1:0] : 2'h0)) | cset;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
            cm_reg <= 2'h0;
        end else begin
            irq_o <= |(uflg_reg & umsk_reg) | |(cflg_reg & cmsk_reg);
            cm_reg <= cset;
        end
    end

    assign timer_pulse_output_o = pulse_reg;
    assign compare_match_o = cm_reg;

    // ----------------------------------------
    // readback with high nibble hold
    // ----------------------------------------
    logic [3:0] hold_reg [NUM_TMR];
    logic [2:0] held_reg;
    logic [7:0] hold_cnt_reg;

    // hold released by high read or timeout
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            held_reg <= 3'h0;
            hold_cnt_reg <= 8'h00;
        end else begin
            for (int i = 0; i < NUM_TMR; i++) begin
                if (bus_i.rd && bus_i.addr == ADR_CNTL0 + 5'(2 * i)) begin
                    held_reg[i] <= 1'b1;
                    hold_reg[i] <= cnt_reg[i][7:4];
                end else if ((bus_i.rd && bus_i.addr == ADR_CNTH0 + 5'(2 * i))
                             || hold_cnt_reg == 8'(HOLD_MAX)) begin
                    held_reg[i] <= 1'b0;
                end
            end
            hold_cnt_reg <= (|held_reg && hold_cnt_reg != 8'(HOLD_MAX))
                            ? hold_cnt_reg + 8'h01 : 8'h00;
        end
    end

    logic [7:0] rd_next;
    always_comb begin
        rd_next = 8'h00;
        unique case (bus_i.addr)
            ADR_MODE: rd_next = {4'h0, mode_reg};
            ADR_CKSEL: rd_next = {5'h00, cksel_reg};
            ADR_CTL0: rd_next = {4'h0, ps_reg[0], 1'b0, run_reg[0]};
            ADR_CTL1: rd_next = {4'h0, ps_reg[1], 1'b0, run_reg[1]};
            ADR_CTL2: rd_next = {4'h0, ps_reg[2], 1'b0, run_reg[2]};
            ADR_PWM: rd_next = {6'h00, pwm_reg};
            ADR_RLD0: rd_next = rld_reg[0];
            ADR_RLD1: rd_next = rld_reg[1];
            ADR_RLD2: rd_next = rld_reg[2];
            ADR_CMP0: rd_next = cmp_reg[0];
            ADR_CMP1: rd_next = cmp_reg[1];
            ADR_CNTL0: rd_next = {4'h0, cnt_reg[0][3:0]};
            ADR_CNTH0: rd_next = {4'h0, held_reg[0] ? hold_reg[0]
                                                   : cnt_reg[0][7:4]};
            ADR_CNTL1: rd_next = {4'h0, cnt_reg[1][3:0]};
            ADR_CNTH1: rd_next = {4'h0, held_reg[1] ? hold_reg[1]
                                                   : cnt_reg[1][7:4]};
            ADR_CNTL2: rd_next = {4'h0, cnt_reg[2][3:0]};
            ADR_CNTH2: rd_next = {4'h0, held_reg[2] ? hold_reg[2]
                                                   : cnt_reg[2][7:4]};
            ADR_UFLG: rd_next = {5'h00, uflg_reg};
            ADR_CFLG: rd_next = {6'h00, cflg_reg};
            ADR_UMSK: rd_next = {5'h00, umsk_reg};
            ADR_CMSK: rd_next = {6'h00, cmsk_reg};
            default: rd_next = 8'h00;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_o <= 8'h00;
        end else if (bus_i.rd) begin
            rdata_o <= rd_next;
        end else begin
            rdata_o <= 8'h00;
        end
    end
endmodule : ptm_timer
`default_nettype wire

// ---- src/ptm_pkg.sv ----
// package: register map, fields and timing for the three-channel timer
`default_nettype none
package ptm_pkg;
    localparam int NUM_TMR = 3;
    localparam logic [4:0] ADR_MODE = 5'h00;
    localparam logic [4:0] ADR_CKSEL = 5'h01;
    localparam logic [4:0] ADR_CTL0 = 5'h02;
    localparam logic [4:0] ADR_CTL1 = 5'h03;
    localparam logic [4:0] ADR_CTL2 = 5'h04;
    localparam logic [4:0] ADR_PWM = 5'h05;
    localparam logic [4:0] ADR_RLD0 = 5'h06;
    localparam logic [4:0] ADR_RLD1 = 5'h07;
    localparam logic [4:0] ADR_RLD2 = 5'h08;
    localparam logic [4:0] ADR_CMP0 = 5'h09;
    localparam logic [4:0] ADR_CMP1 = 5'h0A;
    localparam logic [4:0] ADR_CNTL0 = 5'h0B;
    localparam logic [4:0] ADR_CNTH0 = 5'h0C;
    localparam logic [4:0] ADR_CNTL1 = 5'h0D;
    localparam logic [4:0] ADR_CNTH1 = 5'h0E;
    localparam logic [4:0] ADR_CNTL2 = 5'h0F;
    localparam logic [4:0] ADR_CNTH2 = 5'h10;
    localparam logic [4:0] ADR_UFLG = 5'h11;
    localparam logic [4:0] ADR_CFLG = 5'h12;
    localparam logic [4:0] ADR_UMSK = 5'h13;
    localparam logic [4:0] ADR_CMSK = 5'h14;
    // mode register bits
    localparam int MODE_CASCADE = 3;
    localparam int MODE_EVENT = 2;
    localparam int MODE_FILTER = 1;
    localparam int MODE_POL = 0;
    // control register bits
    localparam int CTL_RUN = 0;
    localparam int CTL_RST = 1;
    localparam int CTL_PS_LO = 2;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [1:0] PS_DIV1 = 2'h0;
    localparam logic [1:0] PS_DIV4 = 2'h1;
    localparam logic [1:0] PS_DIV32 = 2'h2;
    localparam logic [1:0] PS_DIV256 = 2'h3;
    localparam int FILTER_EDGES = 2;
    localparam int HOLD_MAX = 255;

    typedef struct packed {
        logic [4:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } ptm_bus_t;

    typedef struct packed {
        logic [2:0] underflow;
        logic [1:0] compare;
    } ptm_evt_t;
endpackage : ptm_pkg
`default_nettype wire

// ---- sim/ptm_timer_asserts.sv ----
// checker: port-level properties of the three-channel timer
`default_nettype none
module ptm_timer_asserts
    import ptm_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire ptm_pkg::ptm_bus_t bus_i,
    input wire logic [2:0] timer_pulse_output_o,
    input wire logic [1:0] compare_match_o,
    input wire logic irq_o
);
    // ----------------------------------------
    // shadow of the controls seen on the bus
    // ----------------------------------------
    logic [1:0] pwm_reg, cmsk_reg;
    logic [2:0] umsk_reg, stop0_reg, stop2_reg;
    logic run0_reg, run2_reg, casc_reg;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            casc_reg <= 1'b0;
            pwm_reg <= 2'h0;
            cmsk_reg <= 2'h0;
            umsk_reg <= 3'h0;
            run0_reg <= 1'b0;
            run2_reg <= 1'b0;
        end else if (bus_i.wr) begin
            case (bus_i.addr)
                ADR_MODE: casc_reg <= bus_i.wdata[MODE_CASCADE];
                ADR_PWM: pwm_reg <= bus_i.wdata[1:0];
                ADR_CMSK: cmsk_reg <= bus_i.wdata[1:0];
                ADR_UMSK: umsk_reg <= bus_i.wdata[2:0];
                ADR_CTL0: run0_reg <= bus_i.wdata[CTL_RUN];
                ADR_CTL2: run2_reg <= bus_i.wdata[CTL_RUN];
                default: ;
            endcase
        end
    end
    // saturating idle counts: ticks in flight settle within a few cycles
    always_ff @(posedge clk_i) begin
        if (rst_i || run0_reg) stop0_reg <= 3'h0;
        else if (stop0_reg != 3'h7) stop0_reg <= stop0_reg + 3'h1;
    end
    always_ff @(posedge clk_i) begin
        if (rst_i || run2_reg) stop2_reg <= 3'h0;
        else if (stop2_reg != 3'h7) stop2_reg <= stop2_reg + 3'h1;
    end
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // cascade routes timer 0 matches to the timer 1 compare match output
    property p_cmp_pwm;
        (compare_match_o & ~(casc_reg ? {|pwm_reg, 1'b0} : pwm_reg)) == 2'h0;
    endproperty
    a_cmp_pwm: assert property (p_cmp_pwm)
        else $error("compare pulse outside pwm mode");
    property p_cmp_pulse;
        compare_match_o != 2'h0 |=> compare_match_o == 2'h0;
    endproperty
    a_cmp_pulse: assert property (p_cmp_pulse)
        else $error("compare pulse longer than one cycle");
    property p_pwm_fall;
        pwm_reg[0] && compare_match_o[0]
            |-> ##[0:1] !timer_pulse_output_o[0];
    endproperty
    a_pwm_fall: assert property (p_pwm_fall)
        else $error("pwm output not low after match");
    property p_irq_masked;
        umsk_reg == 3'h0 && cmsk_reg == 2'h0 && $past(umsk_reg) == 3'h0
            && $past(cmsk_reg) == 2'h0 |-> !irq_o;
    endproperty
    a_irq_masked: assert property (p_irq_masked)
        else $error("request with all masks closed");
    property p_irq_fwd; compare_match_o[0] && cmsk_reg[0] |-> ##[0:2] irq_o;
    endproperty
    a_irq_fwd: assert property (p_irq_fwd)
        else $error("open compare request not forwarded");
    property p_hold0; stop0_reg >= 3'h4 |-> $stable(timer_pulse_output_o[0]);
    endproperty
    a_hold0: assert property (p_hold0)
        else $error("timer 0 output moved while stopped");
    property p_hold2; stop2_reg >= 3'h4 |-> $stable(timer_pulse_output_o[2]);
    endproperty
    a_hold2: assert property (p_hold2)
        else $error("timer 2 output moved while stopped");
    property p_rst_out;
        $fell(rst_i) |-> irq_o == 1'b0 && compare_match_o == 2'h0
            && timer_pulse_output_o == 3'h0;
    endproperty
    a_rst_out: assert property (p_rst_out)
        else $error("outputs not clear after reset");
    c_match: cover property (compare_match_o[0]);
    c_irq: cover property ($rose(irq_o));
    c_tgl: cover property ($changed(timer_pulse_output_o[2]));
endmodule : ptm_timer_asserts
bind ptm_timer ptm_timer_asserts u_chk (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .bus_i(bus_i),
    .timer_pulse_output_o(timer_pulse_output_o),
    .compare_match_o(compare_match_o),
    .irq_o(irq_o)
);
`default_nettype wire

// ---- sim/ptm_timer_tb_top.sv ----
// testbench: register-level scenarios for the three-channel timer
`default_nettype none
module ptm_timer_tb_top import ptm_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------
    // clocks, bus and instance
    // ----------------------------------------
    logic clk_i = 1'b0, rst_i = 1'b1, slow = 1'b0, fast = 1'b0;
    logic refc = 1'b0, pin = 1'b0, irq;
    ptm_bus_t bus = '0;
    logic [7:0] rdata;
    logic [2:0] tpo;
    logic [1:0] cmo;
    int mismatches = 0, cmp_count = 0;
    int tc = 0;
    always #50 clk_i = ~clk_i;
    // sources: slow 8, fast 6, reference 20 bus cycles a period
    // fast source below a quarter of the bus clock, stable from power-up
    // reference sped up so filter runs stay short
    always @(posedge clk_i) begin
        tc <= tc + 1;
        if (tc % 4 == 3) slow <= ~slow;
        if (tc % 3 == 2) fast <= ~fast;
        if (tc % 10 == 9) refc <= ~refc;
    end
    ptm_timer uut (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .low_speed_source_clock_i(slow),
        .high_speed_source_clock_i(fast),
        .filter_ref_clock_i(refc),
        .event_input_pin_i(pin),
        .bus_i(bus),
        .rdata_o(rdata),
        .timer_pulse_output_o(tpo),
        .compare_match_o(cmo),
        .irq_o(irq)
    );
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic cycles(input int n);
        repeat (n) @(posedge clk_i);
    endtask : cycles
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge clk_i);
        bus.addr <= a;
        bus.wdata <= d;
        bus.wr <= 1'b1;
        @(posedge clk_i);
        bus.wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [4:0] a, output logic [7:0] d);
        @(posedge clk_i);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge clk_i);
        bus.rd <= 1'b0;
        #1 d = rdata;
    endtask : rd
    task automatic rdcnt(input int i, output logic [7:0] v);
        logic [7:0] l, h;
        rd(5'(ADR_CNTL0 + 2 * i), l);
        rd(5'(ADR_CNTH0 + 2 * i), h);
        v = {h[3:0], l[3:0]};
    endtask : rdcnt
    task automatic chk(input string n, input logic [7:0] e, g);
        cmp_count++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic chk_rng(input string n, input logic [7:0] lo, hi, g);
        cmp_count++;
        if (!(g >= lo && g <= hi) || $isunknown(g)) begin
            mismatches++;
            $display("mismatch %s expected %h..%h seen %h", n, lo, hi, g);
        end
    endtask : chk_rng
    task automatic stop(input logic [4:0] a);
        wr(a, 8'h00);
        cycles(8);
    endtask : stop
    task automatic set_pin(input logic v, input int n);
        @(posedge clk_i);
        pin <= v;
        cycles(n);
    endtask : set_pin
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : complete_run
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_hold();
        logic [7:0] a, b;
        rd(ADR_UFLG, a);
        chk("uflg reset", 8'h00, a);
        rd(5'h1F, a);
        chk("unmapped", 8'h00, a);
        wr(ADR_RLD2, 8'h80);
        wr(ADR_CTL2, 8'h03);
        cycles(80);
        stop(ADR_CTL2);
        rdcnt(2, a);
        chk_rng("cnt2 run", 8'h74, 8'h7E, a);
        cycles(60);
        rdcnt(2, b);
        chk("cnt2 held", a, b);
        wr(ADR_CTL2, 8'h02);
        rdcnt(2, b);
        chk("cnt2 reload", 8'h80, b);
    endtask : t_hold
    task automatic t_ratio();
        int rat[4] = '{1, 4, 32, 256};
        logic [7:0] a;
        wr(ADR_CKSEL, 8'h04);
        wr(ADR_RLD2, 8'hFF);
        for (int k = 0; k < 4; k++) begin
            wr(ADR_CTL2, {4'h0, 2'(k), 2'h2});
            wr(ADR_CTL2, {4'h0, 2'(k), 2'h1});
            cycles(96 * rat[k]);
            stop(ADR_CTL2);
            rdcnt(2, a);
            chk_rng("ratio", 8'hED, 8'hF1, a);
        end
        wr(ADR_CKSEL, 8'h00);
        wr(ADR_CTL2, 8'h02);
        wr(ADR_CTL2, 8'h01);
        cycles(96);
        stop(ADR_CTL2);
        rdcnt(2, a);
        chk_rng("slow source", 8'hF1, 8'hF5, a);
    endtask : t_ratio
    task automatic t_uflow();
        logic [7:0] d;
        int n;
        wr(ADR_CKSEL, 8'h04);
        wr(ADR_RLD2, 8'h03);
        wr(ADR_CTL2, 8'h03);
        // timer 2 has not underflowed before, so its output starts low
        n = 0;
        while (tpo[2] !== 1'b1 && n < 100) begin
            @(negedge clk_i);
            n++;
        end
        chk("t2 toggle", 8'h01, {7'h0, tpo[2]});
        cycles(100);
        chk("irq masked", 8'h00, {7'h0, irq});
        wr(ADR_UMSK, 8'h04);
        cycles(3);
        chk("irq open", 8'h01, {7'h0, irq});
        stop(ADR_CTL2);
        rdcnt(2, d);
        chk_rng("cnt2 wrap", 8'h00, 8'h03, d);
        rd(ADR_UFLG, d);
        chk("uflg2", 8'h04, d);
        wr(ADR_UFLG, 8'h00);
        rd(ADR_UFLG, d);
        chk("uflg keep", 8'h04, d);
        wr(ADR_UFLG, 8'h04);
        rd(ADR_UFLG, d);
        chk("uflg clear", 8'h00, d);
        chk("irq clear", 8'h00, {7'h0, irq});
        wr(ADR_UMSK, 8'h00);
    endtask : t_uflow
    task automatic t_pwm();
        logic [7:0] d;
        int n;
        wr(ADR_CKSEL, 8'h03);
        wr(ADR_RLD0, 8'h08);
        wr(ADR_CMP0, 8'h03);
        wr(ADR_RLD1, 8'h08);
        wr(ADR_CMP1, 8'h03);
        wr(ADR_PWM, 8'h01);
        wr(ADR_CMSK, 8'h01);
        wr(ADR_CTL0, 8'h03);
        wr(ADR_CTL1, 8'h03);
        n = 0;
        while (cmo[0] !== 1'b1 && n < 200) begin
            @(negedge clk_i);
            n++;
        end
        chk("match", 8'h01, {7'h0, cmo[0]});
        repeat (2) @(negedge clk_i);
        chk("pwm low", 8'h00, {7'h0, tpo[0]});
        n = 0;
        while (tpo[0] !== 1'b1 && n < 200) begin
            @(negedge clk_i);
            n++;
        end
        chk("pwm high", 8'h01, {7'h0, tpo[0]});
        chk("cmp irq", 8'h01, {7'h0, irq});
        stop(ADR_CTL0);
        stop(ADR_CTL1);
        rd(ADR_CFLG, d);
        chk("cflg", 8'h01, d);
        wr(ADR_CFLG, 8'h03);
        wr(ADR_CMP0, 8'h09);
        wr(ADR_CTL0, 8'h03);
        cycles(300);
        chk("pwm stuck", 8'h01, {7'h0, tpo[0]});
        stop(ADR_CTL0);
        rd(ADR_CFLG, d);
        chk("no match", 8'h00, d);
        wr(ADR_PWM, 8'h02);
        wr(ADR_CTL1, 8'h03);
        n = 0;
        while (cmo[1] !== 1'b1 && n < 200) begin
            @(negedge clk_i);
            n++;
        end
        chk("match t1", 8'h01, {7'h0, cmo[1]});
        stop(ADR_CTL1);
        rd(ADR_CFLG, d);
        chk("cflg t1", 8'h02, d);
        wr(ADR_PWM, 8'h00);
        wr(ADR_CMSK, 8'h00);
    endtask : t_pwm
    task automatic t_casc();
        logic [7:0] a, b;
        wr(ADR_UFLG, 8'h07);
        wr(ADR_CFLG, 8'h03);
        wr(ADR_MODE, 8'h08);
        wr(ADR_PWM, 8'h01);
        wr(ADR_CMP0, 8'h01);
        wr(ADR_RLD0, 8'h02);
        wr(ADR_RLD1, 8'h05);
        wr(ADR_CTL1, 8'h02);
        wr(ADR_CTL0, 8'h03);
        cycles(80);
        stop(ADR_CTL0);
        rdcnt(0, a);
        rdcnt(1, b);
        chk_rng("cnt1 cascade", 8'h00, 8'h03, b);
        rd(ADR_UFLG, a);
        chk("uflg cascade", 8'h00, a);
        rd(ADR_CFLG, a);
        chk("cflg cascade", 8'h02, a);
        wr(ADR_PWM, 8'h00);
        wr(ADR_MODE, 8'h00);
    endtask : t_casc
    task automatic t_event();
        logic [7:0] a;
        logic [7:0] mode[3] = '{8'h04, 8'h05, 8'h07};
        logic [7:0] expv[3] = '{8'h0F, 8'h0E, 8'h0F};
        for (int k = 0; k < 3; k++) begin
            wr(ADR_MODE, mode[k]);
            wr(ADR_RLD0, 8'h10);
            wr(ADR_CTL0, 8'h02);
            wr(ADR_CTL0, 8'h01);
            if (k == 2) begin
                set_pin(1'b0, 3);
                set_pin(1'b1, 60);
                set_pin(1'b0, 60);
                set_pin(1'b1, 60);
            end else begin
                set_pin(1'b1, 20);
                set_pin(1'b0, 20);
                set_pin(1'b1, 20);
            end
            stop(ADR_CTL0);
            rdcnt(0, a);
            chk("event count", expv[k], a);
            if (k == 0) set_pin(1'b0, 20);
        end
        wr(ADR_MODE, 8'h00);
    endtask : t_event
    // scenarios take about 30k cycles; the limit allows 50k
    initial begin
        #5_000_000;
        mismatches++;
        complete_run();
    end
    initial begin
        cycles(10);
        rst_i <= 1'b0;
        t_hold();
        t_ratio();
        t_uflow();
        t_pwm();
        t_casc();
        t_event();
        complete_run();
    end
endmodule : ptm_timer_tb_top
`default_nettype wire
